//--- drive_sel_pkg.sv
// Package with codes, register map and constants for the output signal selector
package drive_sel_pkg;

  // Data widths
  localparam int VAL_W = 16;
  localparam int CODE_W = 5;
  localparam int ADDR_W = 8;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_SEL_DIGITAL = 8'h00;
  localparam logic [7:0] OFS_SEL_RELAY_A = 8'h04;
  localparam logic [7:0] OFS_SEL_RELAY_B = 8'h08;
  localparam logic [7:0] OFS_FREQ_SUP1 = 8'h0C;
  localparam logic [7:0] OFS_FREQ_SUP2 = 8'h10;
  localparam logic [7:0] OFS_TORQUE_SUP = 8'h14;
  localparam logic [7:0] OFS_REF_SUP = 8'h18;
  localparam logic [7:0] OFS_ANALOG_CFG = 8'h1C;
  localparam logic [7:0] OFS_BRAKE_DLY = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_ANALOG_OUT = 8'h28;

  // Field positions
  localparam int SUP_MODE_LSB = 16;
  localparam int ANA_SRC_LSB = 0;
  localparam int ANA_INV_BIT = 4;
  localparam int ANA_FLOOR_BIT = 5;
  localparam int ANA_SCALE_LSB = 16;
  localparam int BRK_OFF_LSB = 0;
  localparam int BRK_ON_LSB = 16;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [15:0] RST_SCALE = 16'h0100;

  // Analog output: level range 0..20 mA in 16 bits, 4 mA floor
  localparam logic [15:0] AO_FULL = 16'hFFFF;
  localparam logic [15:0] AO_FLOOR_4MA = 16'h3333;
  localparam logic [15:0] AO_SPAN_4MA = 16'hCCCC;
  // Scale factor unity (8.8 fixed point)
  localparam int SCALE_FRAC = 8;

  // Heat-sink warning threshold, degrees Celsius
  localparam logic [15:0] HEATSINK_WARN_C = 16'h0046;

  // Brake delay tick: 1 ms at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int BRAKE_TICK_US = 1000;
  localparam int BRAKE_TICK_CYC = CLK_MHZ * BRAKE_TICK_US;

  // Supervision modes
  typedef enum logic [1:0] {
    SUP_OFF = 2'h0,
    SUP_LOW = 2'h1,
    SUP_HIGH = 2'h2
  } sup_mode_t;

  // Output selection codes
  localparam logic [4:0] SEL_NONE = 5'h00;
  localparam logic [4:0] SEL_READY = 5'h01;
  localparam logic [4:0] SEL_RUN = 5'h02;
  localparam logic [4:0] SEL_FAULT = 5'h03;
  localparam logic [4:0] SEL_NO_FAULT = 5'h04;
  localparam logic [4:0] SEL_OVERHEAT = 5'h05;
  localparam logic [4:0] SEL_EXT_FAULT = 5'h06;
  localparam logic [4:0] SEL_REF_FAULT = 5'h07;
  localparam logic [4:0] SEL_WARNING = 5'h08;
  localparam logic [4:0] SEL_REVERSE = 5'h09;
  localparam logic [4:0] SEL_PRESET = 5'h0A;
  localparam logic [4:0] SEL_AT_SPEED = 5'h0B;
  localparam logic [4:0] SEL_REGULATOR = 5'h0C;
  localparam logic [4:0] SEL_FREQ_SUP1 = 5'h0D;
  localparam logic [4:0] SEL_FREQ_SUP2 = 5'h0E;
  localparam logic [4:0] SEL_TORQUE_SUP = 5'h0F;
  localparam logic [4:0] SEL_REF_SUP = 5'h10;
  localparam logic [4:0] SEL_BRAKE = 5'h11;
  localparam logic [4:0] SEL_IO_CTRL = 5'h12;
  localparam logic [4:0] SEL_TEMP_SUP = 5'h13;
  localparam logic [4:0] SEL_WRONG_DIR = 5'h14;
  localparam logic [4:0] SEL_BRAKE_INV = 5'h15;
  localparam logic [4:0] SEL_AUX1 = 5'h1C;
  localparam logic [4:0] SEL_AUX2 = 5'h1D;
  localparam logic [4:0] SEL_AUX3 = 5'h1E;

  // Analog sources
  localparam logic [3:0] AS_FREQ = 4'h0;
  localparam logic [3:0] AS_SPEED = 4'h1;
  localparam logic [3:0] AS_CURRENT = 4'h2;
  localparam logic [3:0] AS_TORQUE = 4'h3;
  localparam logic [3:0] AS_POWER = 4'h4;
  localparam logic [3:0] AS_VOLT = 4'h5;
  localparam logic [3:0] AS_DCLINK = 4'h6;
  localparam logic [3:0] AS_PI_REF = 4'h7;
  localparam logic [3:0] AS_PI_ACT1 = 4'h8;
  localparam logic [3:0] AS_PI_ACT2 = 4'h9;
  localparam logic [3:0] AS_PI_ERR = 4'hA;
  localparam logic [3:0] AS_PI_OUT = 4'hB;
  localparam logic [15:0] DCLINK_FULL_V = 16'h03E8;

  // Limit comparison used by the frequency, torque and reference supervisors
  function automatic logic sup_flag(input logic [1:0] mode, input logic [15:0] val,
                                    input logic [15:0] lim);
    case (mode)
      SUP_LOW: sup_flag = val < lim;
      SUP_HIGH: sup_flag = val > lim;
      default: sup_flag = 1'b0;
    endcase
  endfunction : sup_flag

endpackage : drive_sel_pkg

//--- status_bus_if.sv
// Interface carrying drive status conditions to the selectors
`timescale 1ns/1ps
interface status_bus_if;
  logic [31:0] cond;
  modport src (output cond);
  modport dst (input cond);
endinterface : status_bus_if

//--- output_selector.sv
// One registered output picked from the shared condition table
`timescale 1ns/1ps
module output_selector
  import drive_sel_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Conditions and selection
  status_bus_if.dst conds,
  input wire logic [4:0] code,
  // Output
  output logic active
);

  // Code zero and unused codes index bits held low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      active <= 1'b0;
    end else begin
      active <= conds.cond[code];
    end
  end

endmodule : output_selector

//--- drive_output_signal_selector.sv
// Top of the output signal selection, limit supervision and analog output
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module drive_output_signal_selector
  import drive_sel_pkg::*;
#(
  parameter int TICK_CYC = BRAKE_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Drive status inputs (from pins or other clock sources)
  input wire logic drive_ready,
  input wire logic motor_running,
  input wire logic fault_active,
  input wire logic ext_fault,
  input wire logic ref_4_20_mode,
  input wire logic any_warning,
  input wire logic reverse_sel,
  input wire logic preset_speed_sel,
  input wire logic regulator_active,
  input wire logic io_ctrl_sel,
  input wire logic temp_sup_out,
  input wire logic wrong_direction,
  input wire logic start_cmd,
  input wire logic [2:0] aux_start,
  // Measurements, same clock domain
  input wire logic [15:0] out_freq,
  input wire logic [15:0] ref_freq,
  input wire logic [15:0] active_ref,
  input wire logic [15:0] torque,
  input wire logic [15:0] heatsink_temp,
  input wire logic [15:0] ref_current,
  input wire logic [15:0] ref_4ma_level,
  // Analog sources and their full-scale values
  input wire logic [15:0] ana_val [12],
  input wire logic [15:0] ana_full [12],
  // Outputs
  output logic sinking_digital_output,
  output logic relay_output_a,
  output logic relay_output_b,
  output logic [15:0] analog_level
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] s;

  assign raw_in = {aux_start, start_cmd, wrong_direction, temp_sup_out, io_ctrl_sel,
                   regulator_active, preset_speed_sel, reverse_sel, any_warning,
                   ref_4_20_mode, ext_fault, fault_active, motor_running, drive_ready};

  // Two flops ahead of any logic
  // The first stage may go metastable, so only the second one is read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1 <= '0;
      s <= '0;
    end else begin
      sync1 <= raw_in;
      s <= sync1;
    end
  end

  // Named views of the synchronised start and auxiliary levels
  logic start_sync;
  logic [2:0] aux_sync;
  assign start_sync = s[12];
  assign aux_sync = s[15:13];

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [4:0] sel_digital;
  logic [4:0] sel_relay_a;
  logic [4:0] sel_relay_b;
  logic [31:0] freq_sup1;
  logic [31:0] freq_sup2;
  logic [31:0] torque_sup;
  logic [31:0] ref_sup;
  logic [31:0] analog_cfg;
  logic [31:0] brake_dly;

  // Register writes
  // Supervisor words keep only limit and mode; other bits read back zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_digital <= SEL_NONE;
      sel_relay_a <= SEL_NONE;
      sel_relay_b <= SEL_NONE;
      freq_sup1 <= RST_ZERO;
      freq_sup2 <= RST_ZERO;
      torque_sup <= RST_ZERO;
      ref_sup <= RST_ZERO;
      analog_cfg <= {RST_SCALE, 16'h0000};
      brake_dly <= RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_SEL_DIGITAL: sel_digital <= reg_wdata[4:0];
        OFS_SEL_RELAY_A: sel_relay_a <= reg_wdata[4:0];
        OFS_SEL_RELAY_B: sel_relay_b <= reg_wdata[4:0];
        OFS_FREQ_SUP1: freq_sup1 <= {14'h0000, reg_wdata[17:0]};
        OFS_FREQ_SUP2: freq_sup2 <= {14'h0000, reg_wdata[17:0]};
        OFS_TORQUE_SUP: torque_sup <= {14'h0000, reg_wdata[17:0]};
        OFS_REF_SUP: ref_sup <= {14'h0000, reg_wdata[17:0]};
        OFS_ANALOG_CFG: analog_cfg <= {reg_wdata[31:16], 10'h000, reg_wdata[5:0]};
        OFS_BRAKE_DLY: brake_dly <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Supervisors
  // ------------------------------------------------------------
  logic sup1_out;
  logic sup2_out;
  logic torque_out;
  logic ref_out;
  logic overheat;
  logic ref_low;
  logic at_speed;

  // Limit flags registered every cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sup1_out <= 1'b0;
      sup2_out <= 1'b0;
      torque_out <= 1'b0;
      ref_out <= 1'b0;
      overheat <= 1'b0;
      ref_low <= 1'b0;
      at_speed <= 1'b0;
    end else begin
      sup1_out <= sup_flag(freq_sup1[17:16], out_freq, freq_sup1[15:0]);
      sup2_out <= sup_flag(freq_sup2[17:16], out_freq, freq_sup2[15:0]);
      torque_out <= sup_flag(torque_sup[17:16], torque, torque_sup[15:0]);
      ref_out <= sup_flag(ref_sup[17:16], active_ref, ref_sup[15:0]);
      overheat <= heatsink_temp > HEATSINK_WARN_C;
      ref_low <= ref_current < ref_4ma_level;
      at_speed <= out_freq == ref_freq;
    end
  end

  // ------------------------------------------------------------
  // External brake delay
  // ------------------------------------------------------------
  logic brake_ctrl;
  logic [31:0] tick_cnt;
  logic [15:0] dly_cnt;
  logic [15:0] brake_target;

  // Release delay while starting, engage delay while stopping
  assign brake_target = start_sync ? brake_dly[BRK_OFF_LSB +: 16]
                                   : brake_dly[BRK_ON_LSB +: 16];

  // Brake follows start after release delay, stop after engage delay
  // A command that flips back before its delay runs out restarts the count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      brake_ctrl <= 1'b0;
      tick_cnt <= '0;
      dly_cnt <= '0;
    end else if (start_sync == brake_ctrl) begin
      tick_cnt <= '0;
      dly_cnt <= '0;
    end else if (dly_cnt >= brake_target) begin
      brake_ctrl <= start_sync;
      tick_cnt <= '0;
      dly_cnt <= '0;
    end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
      tick_cnt <= '0;
      dly_cnt <= dly_cnt + 16'h0001;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // Condition table and selectors
  // ------------------------------------------------------------
  status_bus_if conds ();

  // Shared code table; unused codes stay low
  always_comb begin
    conds.cond = 32'h0000_0000;
    conds.cond[SEL_READY] = s[0];
    conds.cond[SEL_RUN] = s[1];
    conds.cond[SEL_FAULT] = s[2];
    conds.cond[SEL_NO_FAULT] = ~s[2];
    conds.cond[SEL_OVERHEAT] = overheat;
    conds.cond[SEL_EXT_FAULT] = s[3];
    conds.cond[SEL_REF_FAULT] = s[4] & ref_low;
    conds.cond[SEL_WARNING] = s[5];
    conds.cond[SEL_REVERSE] = s[6];
    conds.cond[SEL_PRESET] = s[7];
    conds.cond[SEL_AT_SPEED] = at_speed;
    conds.cond[SEL_REGULATOR] = s[8];
    conds.cond[SEL_FREQ_SUP1] = sup1_out;
    conds.cond[SEL_FREQ_SUP2] = sup2_out;
    conds.cond[SEL_TORQUE_SUP] = torque_out;
    conds.cond[SEL_REF_SUP] = ref_out;
    conds.cond[SEL_BRAKE] = brake_ctrl;
    conds.cond[SEL_IO_CTRL] = s[9];
    conds.cond[SEL_TEMP_SUP] = s[10];
    conds.cond[SEL_WRONG_DIR] = s[11];
    conds.cond[SEL_BRAKE_INV] = ~brake_ctrl;
    conds.cond[SEL_AUX1] = aux_sync[0];
    conds.cond[SEL_AUX2] = aux_sync[1];
    conds.cond[SEL_AUX3] = aux_sync[2];
  end

  output_selector u_sel_digital (
    .clk_sys(clk_sys),
    .rst(rst),
    .conds(conds),
    .code(sel_digital),
    .active(sinking_digital_output)
  );

  output_selector u_sel_relay_a (
    .clk_sys(clk_sys),
    .rst(rst),
    .conds(conds),
    .code(sel_relay_a),
    .active(relay_output_a)
  );

  output_selector u_sel_relay_b (
    .clk_sys(clk_sys),
    .rst(rst),
    .conds(conds),
    .code(sel_relay_b),
    .active(relay_output_b)
  );

  // ------------------------------------------------------------
  // Analog output
  // ------------------------------------------------------------
  logic [3:0] src;
  logic [15:0] full;
  logic [15:0] val;
  logic [15:0] scale;
  logic [31:0] prod;
  logic [31:0] frac;
  logic [15:0] norm;
  logic [15:0] inv;
  logic [31:0] lvl4;
  logic [15:0] next_level;

  // Codes past the last controller quantity fall back to output frequency
  assign src = (analog_cfg[3:0] > AS_PI_OUT) ? AS_FREQ : analog_cfg[3:0];
  // Full scale per source: values supplied already as max freq, 2x nominal, etc.; DC link uses the fixed DCLINK_FULL_V
  assign full = (src == AS_DCLINK) ? DCLINK_FULL_V : ana_full[src];
  assign val = ana_val[src];
  assign scale = analog_cfg[ANA_SCALE_LSB +: 16];
  // Scale is 8.8 fixed point; a 16 by 16 product always fits 32 bits
  assign prod = (32'(val) * 32'(scale)) >> SCALE_FRAC;

  // Normalise to 0..AO_FULL with saturation
  always_comb begin
    frac = 32'h0000_0000;
    // Saturate before the product with full scale could overflow
    if (full == 16'h0000) begin
      frac = 32'h0000_0000;
    end else if (prod >= 32'(full)) begin
      frac = 32'(AO_FULL);
    end else begin
      frac = (prod * 32'(AO_FULL)) / 32'(full);
    end
    norm = (frac > 32'(AO_FULL)) ? AO_FULL : frac[15:0];
    inv = analog_cfg[ANA_INV_BIT] ? (AO_FULL - norm) : norm;
    lvl4 = (32'(inv) * 32'(AO_SPAN_4MA)) / 32'(AO_FULL);
    next_level = analog_cfg[ANA_FLOOR_BIT] ? (AO_FLOOR_4MA + lvl4[15:0]) : inv;
  end

  // Registered analog level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      analog_level <= 16'h0000;
    end else begin
      analog_level <= next_level;
    end
  end

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= RST_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_SEL_DIGITAL: reg_rdata <= {27'h000_0000, sel_digital};
        OFS_SEL_RELAY_A: reg_rdata <= {27'h000_0000, sel_relay_a};
        OFS_SEL_RELAY_B: reg_rdata <= {27'h000_0000, sel_relay_b};
        OFS_FREQ_SUP1: reg_rdata <= freq_sup1;
        OFS_FREQ_SUP2: reg_rdata <= freq_sup2;
        OFS_TORQUE_SUP: reg_rdata <= torque_sup;
        OFS_REF_SUP: reg_rdata <= ref_sup;
        OFS_ANALOG_CFG: reg_rdata <= analog_cfg;
        OFS_BRAKE_DLY: reg_rdata <= brake_dly;
        OFS_STATUS: reg_rdata <= {21'h00_0000, brake_ctrl, ref_low, overheat, ref_out,
                                  torque_out, sup2_out, sup1_out, 1'b0,
                                  relay_output_b, relay_output_a, sinking_digital_output};
        OFS_ANALOG_OUT: reg_rdata <= {16'h0000, analog_level};
        default: reg_rdata <= RST_ZERO;
      endcase
    end else begin
      reg_rdata <= RST_ZERO;
    end
  end

endmodule : drive_output_signal_selector

//--- plant_equipment.sv
// Plant-side load model wired to the drive outputs
`timescale 1ns/1ps
module plant_equipment (
  // Clock
  input wire logic clk_sys,
  // Drive outputs
  input wire logic sinking_digital_output,
  input wire logic relay_output_a,
  input wire logic relay_output_b,
  // Contact feedback
  output logic [2:0] contacts
);
  // Contacts pick up one cycle after the coil or sink changes
  always_ff @(posedge clk_sys) begin
    contacts <= {relay_output_b, relay_output_a, sinking_digital_output};
  end
endmodule : plant_equipment

//--- dos_checker_sva.sv
// Checker for selector latency and supervision at the top ports
`timescale 1ns/1ps
module dos_checker_sva
  import drive_sel_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Status and measurements
  input wire logic drive_ready,
  input wire logic motor_running,
  input wire logic fault_active,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] heatsink_temp,
  // Outputs
  input wire logic sinking_digital_output,
  input wire logic relay_output_a,
  input wire logic relay_output_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [4:0] sel_d;
  logic [4:0] sel_a;
  logic [4:0] sel_b;
  logic [17:0] sup1;
  logic [2:0] quiet;
  // Shadow copies of the selector and frequency supervisor one settings
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_d <= '0;
      sel_a <= '0;
      sel_b <= '0;
      sup1 <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_SEL_DIGITAL: sel_d <= reg_wdata[4:0];
        OFS_SEL_RELAY_A: sel_a <= reg_wdata[4:0];
        OFS_SEL_RELAY_B: sel_b <= reg_wdata[4:0];
        OFS_FREQ_SUP1: sup1 <= reg_wdata[17:0];
        default: ;
      endcase
    end
  end
  // Cycles since the last register write, saturating
  always_ff @(posedge clk_sys) begin
    if (rst || reg_wr) quiet <= '0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  a_code_zero_off: assert property ($past(sel_d) == SEL_NONE |-> !sinking_digital_output)
    else $error("digital output active with code zero");
  a_ready_follows: assert property (sel_d == SEL_READY && quiet > 3'h3
    |-> sinking_digital_output == $past(drive_ready, 3))
    else $error("digital output does not follow ready");
  a_run_follows: assert property (sel_a == SEL_RUN && quiet > 3'h3
    |-> relay_output_a == $past(motor_running, 3))
    else $error("relay a does not follow running");
  a_nofault_inverts: assert property (sel_b == SEL_NO_FAULT && quiet > 3'h3
    |-> relay_output_b == !$past(fault_active, 3))
    else $error("relay b does not show absent fault");
  a_overheat_limit: assert property (sel_d == SEL_OVERHEAT && quiet > 3'h3
    |-> sinking_digital_output == ($past(heatsink_temp, 2) > HEATSINK_WARN_C))
    else $error("overheat output wrong against 70 degrees");
  a_freq_sup_one: assert property (sel_a == SEL_FREQ_SUP1 && quiet > 3'h3
    |-> relay_output_a == (sup1[17:16] == 2'h1 ? $past(out_freq, 2) < sup1[15:0]
    : sup1[17:16] == 2'h2 && $past(out_freq, 2) > sup1[15:0]))
    else $error("frequency supervisor one flag wrong");
  a_unused_low: assert property ((sel_b inside {[5'h16:5'h1B], 5'h1F}) && quiet > 3'h1
    |-> !relay_output_b)
    else $error("relay b active on unused code");

  c_read: cover property (reg_rd ##1 reg_rdata != 32'h0000_0000);
  c_ready_on: cover property (sel_d == SEL_READY && sinking_digital_output);
  c_relay_b_rise: cover property ($rose(relay_output_b));
endmodule : dos_checker_sva

bind drive_output_signal_selector dos_checker_sva dos_checker_sva_i (.clk_sys, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .drive_ready, .motor_running,
  .fault_active, .out_freq, .heatsink_temp, .sinking_digital_output, .relay_output_a,
  .relay_output_b);

//--- drive_output_signal_selector_tb.sv
// Self-checking bench for the output signal selector
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((e) !== (g)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module drive_output_signal_selector_tb
  import drive_sel_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] st = '0;
  logic [15:0] of = '0, rf = '0, ar = '0, tq = '0, heat = '0, rc = '0;
  logic [15:0] ana_val [12];
  logic [15:0] ana_full [12];
  logic dout, ra, rb;
  logic [15:0] alev;
  logic [2:0] contacts;
  logic [1:0] m [4];
  logic [15:0] l [4];
  logic [31:0] d;
  logic [15:0] v;
  int n_mismatch = 0;
  int num_checks = 0;

  // Clock, 10 ns period
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  drive_output_signal_selector #(.TICK_CYC(4)) drive_output_signal_selector_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive_ready(st[0]),
    .motor_running(st[1]), .fault_active(st[2]), .ext_fault(st[3]), .ref_4_20_mode(st[4]),
    .any_warning(st[5]), .reverse_sel(st[6]), .preset_speed_sel(st[7]),
    .regulator_active(st[8]), .io_ctrl_sel(st[9]), .temp_sup_out(st[10]),
    .wrong_direction(st[11]), .start_cmd(st[12]), .aux_start(st[15:13]), .out_freq(of),
    .ref_freq(rf), .active_ref(ar), .torque(tq), .heatsink_temp(heat), .ref_current(rc),
    .ref_4ma_level(16'h0040), .ana_val(ana_val), .ana_full(ana_full),
    .sinking_digital_output(dout), .relay_output_a(ra), .relay_output_b(rb),
    .analog_level(alev));

  plant_equipment plant_equipment_i (.clk_sys(clk_sys), .sinking_digital_output(dout),
    .relay_output_a(ra), .relay_output_b(rb), .contacts(contacts));

  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    x = reg_rdata;
  endtask : rd
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // Expected supervisor flag
  function automatic logic sup(input logic [1:0] md, input logic [15:0] x, input logic [15:0] lim);
    return (md == 2'h1) ? x < lim : (md == 2'h2) && x > lim;
  endfunction : sup
  // Expected condition behind a selection code, inputs held steady
  function automatic logic expv(input logic [4:0] c);
    case (c)
      SEL_READY: expv = st[0];
      SEL_RUN: expv = st[1];
      SEL_FAULT: expv = st[2];
      SEL_NO_FAULT: expv = !st[2];
      SEL_OVERHEAT: expv = heat > 16'h0046;
      SEL_EXT_FAULT: expv = st[3];
      SEL_REF_FAULT: expv = st[4] && rc < 16'h0040;
      SEL_WARNING: expv = st[5];
      SEL_REVERSE: expv = st[6];
      SEL_PRESET: expv = st[7];
      SEL_AT_SPEED: expv = of == rf;
      SEL_REGULATOR: expv = st[8];
      SEL_FREQ_SUP1: expv = sup(m[0], of, l[0]);
      SEL_FREQ_SUP2: expv = sup(m[1], of, l[1]);
      SEL_TORQUE_SUP: expv = sup(m[2], tq, l[2]);
      SEL_REF_SUP: expv = sup(m[3], ar, l[3]);
      SEL_IO_CTRL: expv = st[9];
      SEL_TEMP_SUP: expv = st[10];
      SEL_WRONG_DIR: expv = st[11];
      SEL_BRAKE_INV: expv = 1'b1;
      SEL_AUX1: expv = st[13];
      SEL_AUX2: expv = st[14];
      SEL_AUX3: expv = st[15];
      default: expv = 1'b0;
    endcase
  endfunction : expv

  // Main sequence
  initial begin
    logic [4:0] ca, cb;
    int n;
    for (int i = 0; i < 12; i++) begin
      ana_val[i] = '0;
      ana_full[i] = (i == 6) ? DCLINK_FULL_V : 16'h0800;
    end
    void'($urandom(769));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFS_ANALOG_CFG, d);
    `CHK("scale_reset", {RST_SCALE, 16'h0000}, d)
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, d);
    `CHK("unmapped", 32'h0000_0000, d)
    wr(OFS_SEL_RELAY_A, 32'h0000_000B);
    rd(OFS_SEL_RELAY_A, d);
    `CHK("sel_readback", 5'h0B, d[4:0])
    // Every code on every selector, each selector on its own code
    for (int c = 0; c < 32; c++) begin
      ca = 5'(c + 11);
      cb = 5'(c + 23);
      wr(OFS_SEL_DIGITAL, 32'(c));
      wr(OFS_SEL_RELAY_A, 32'(ca));
      wr(OFS_SEL_RELAY_B, 32'(cb));
      for (int t = 0; t < 3; t++) begin
        for (int k = 0; k < 4; k++) begin
          m[k] = 2'($urandom_range(2));
          l[k] = 16'($urandom_range(127));
          wr(OFS_FREQ_SUP1 + 8'(4 * k), {14'h0000, m[k], l[k]});
        end
        v = 16'($urandom_range(127));
        @(posedge clk_sys);
        st <= 16'($urandom) & 16'hEFFF;
        of <= v;
        rf <= (t == 0) ? v : 16'($urandom_range(127));
        ar <= 16'($urandom_range(127));
        tq <= 16'($urandom_range(127));
        rc <= 16'($urandom_range(127));
        heat <= 16'(60 + $urandom_range(20));
        repeat (6) @(posedge clk_sys);
        #1;
        `CHK("digital", expv(5'(c)), dout)
        `CHK("relay_a", expv(ca), ra)
        `CHK("relay_b", expv(cb), rb)
        `CHK("contacts", {expv(cb), expv(ca), expv(5'(c))}, contacts)
      end
    end
    // Brake control after release and engage delays
    wr(OFS_SEL_DIGITAL, 32'(SEL_BRAKE));
    wr(OFS_SEL_RELAY_B, 32'(SEL_BRAKE_INV));
    wr(OFS_BRAKE_DLY, 32'h0003_0002);
    for (int e = 1; e >= 0; e--) begin
      @(posedge clk_sys);
      st[12] <= e[0];
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("brake_hold", !e[0], dout)
      n = 0;
      while (dout !== e[0] && n < 60) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      if (n == 60) begin
        n_mismatch++;
        end_of_test();
      end
      `CHK("brake_delay", e[0] ? 8 : 12, n)
      `CHK("brake_inv", !e[0], rb)
    end
    // Analog level for every source: full, zero, inverted, floor, scaled
    for (int s = 0; s < 12; s++) begin
      for (int k = 0; k < 6; k++) begin
        wr(OFS_ANALOG_CFG, {(k == 5) ? 16'h0200 : RST_SCALE, 10'h000, k == 4,
          k == 2 || k == 3, 4'(s)});
        @(posedge clk_sys);
        ana_val[s] <= (k == 1 || k == 3 || k == 4) ? 16'h0000 :
          (k == 5) ? ana_full[s] >> 1 : ana_full[s];
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK("analog", (k == 0 || k == 3 || k == 5) ? AO_FULL :
          (k == 4) ? AO_FLOOR_4MA : 16'h0000, alev)
      end
    end
    end_of_test();
  end
endmodule : drive_output_signal_selector_tb
